// ==== hdl/lmm_core.sv ====
`timescale 1ns/1ps
`include "lmm_consts.svh"

module lmm_core (
    input  wire logic                  clk,
    input  wire logic                  rst,
    input  wire logic                  instr_valid,
    input  wire logic [15:0]           instr_word,
    input  wire logic                  ext_set_enable,
    input  wire logic [13:0]           index_base,
    output lmm_pkg::lmm_phase_t        phase,
    output logic [7:0]                 accumulator,
    output logic [7:0]                 bank_select_register,
    output logic [7:0]                 product_high_byte,
    output logic [7:0]                 product_low_byte,
    output lmm_pkg::lmm_file_wr_t      file_wr,
    output logic                       instr_done
);
    import lmm_pkg::*;

    // ************************************************************
    // Quarter phase sequencer
    // ************************************************************
    lmm_phase_t next_phase;

    // Free-running ring so every instruction takes exactly four clocks
    always_comb begin
        case (phase)
            LMM_Q1:  next_phase = LMM_Q2;
            LMM_Q2:  next_phase = LMM_Q3;
            LMM_Q3:  next_phase = LMM_Q4;
            LMM_Q4:  next_phase = LMM_Q1;
            default: next_phase = LMM_Q1;
        endcase
    end

    // Reset parks the ring at Q1 so the first word is taken at once
    always_ff @(posedge clk) begin
        if (rst) begin
            phase <= LMM_Q1;
        end else begin
            phase <= next_phase;
        end
    end

    // ************************************************************
    // Decode (Q1), operand read (Q2), process (Q3)
    // ************************************************************
    lmm_dec_t     dec;
    lmm_dec_t     next_dec;
    logic [7:0]   operand;
    logic [7:0]   next_operand;
    logic [15:0]  product;
    logic [15:0]  next_product;
    logic [13:0]  dest_addr;
    logic [13:0]  next_dest_addr;

    // Words that match no opcode here decode to a no-op
    always_comb begin
        next_dec       = dec;
        next_operand   = operand;
        next_product   = product;
        next_dest_addr = dest_addr;
        if (phase == LMM_Q1) begin
            next_dec.op         = LMM_OP_NONE;
            next_dec.lit        = instr_word[`LMM_LIT_HI:0];
            next_dec.banked     = instr_word[`LMM_ACCESS_BIT];
            next_dec.ext_en     = ext_set_enable;
            next_dec.index_base = index_base;
            if (instr_valid) begin
                if (instr_word[`LMM_OPC8_HI:`LMM_OPC8_LO] == `LMM_OPC_LOAD_LIT) begin
                    next_dec.op = LMM_OP_LOAD_LIT;
                end else if (instr_word[`LMM_OPC8_HI:`LMM_OPC8_LO] == `LMM_OPC_MULTIPLY) begin
                    next_dec.op = LMM_OP_MULTIPLY;
                end else if (instr_word[`LMM_OPC8_HI:`LMM_OPC7_LO] == `LMM_OPC_STORE_ACC) begin
                    next_dec.op = LMM_OP_STORE_ACC;
                end else if (instr_word[`LMM_OPC8_HI:`LMM_OPC10_LO] == `LMM_OPC_LOAD_BANK) begin
                    next_dec.op = LMM_OP_LOAD_BANK;
                end
            end
        end
        // Store reads the accumulator, the others read the literal
        if (phase == LMM_Q2) begin
            next_operand = (dec.op == LMM_OP_STORE_ACC) ? accumulator : dec.lit;
        end
        if (phase == LMM_Q3) begin
            next_product = accumulator * operand;
            if (dec.banked) begin
                next_dest_addr = {bank_select_register[`LMM_BANK_LIT_HI:0], dec.lit};
            end else if (dec.lit <= `LMM_INDEX_LIMIT) begin
                if (dec.ext_en) begin
                    next_dest_addr = dec.index_base + 14'(dec.lit);
                end else begin
                    next_dest_addr = {`LMM_ACCESS_LOW_BANK, dec.lit};
                end
            end else begin
                next_dest_addr = {`LMM_ACCESS_HIGH_BANK, dec.lit};
            end
        end
    end

    // Pipeline state; only registered here, computed above
    always_ff @(posedge clk) begin
        if (rst) begin
            dec       <= '0;
            operand   <= `LMM_ACC_RESET;
            product   <= '0;
            dest_addr <= `LMM_ADDR_RESET;
        end else begin
            dec       <= next_dec;
            operand   <= next_operand;
            product   <= next_product;
            dest_addr <= next_dest_addr;
        end
    end

    // ************************************************************
    // Destination write (Q4)
    // ************************************************************
    logic [7:0]   next_accumulator;
    logic [7:0]   next_bank;
    logic [7:0]   next_prod_hi;
    logic [7:0]   next_prod_lo;
    lmm_file_wr_t next_file_wr;
    logic         next_done;

    // No status flags live here: multiply never reports zero or carry
    always_comb begin
        next_accumulator = accumulator;
        next_bank        = bank_select_register;
        next_prod_hi     = product_high_byte;
        next_prod_lo     = product_low_byte;
        next_file_wr     = '0;
        next_done        = 1'b0;
        if (phase == LMM_Q4) begin
            next_done = (dec.op != LMM_OP_NONE);
            case (dec.op)
                LMM_OP_LOAD_LIT: begin
                    next_accumulator = operand;
                end
                LMM_OP_MULTIPLY: begin
                    next_prod_hi = product[15:8];
                    next_prod_lo = product[7:0];
                end
                LMM_OP_STORE_ACC: begin
                    next_file_wr.en   = 1'b1;
                    next_file_wr.addr = dest_addr;
                    next_file_wr.data = operand;
                end
                LMM_OP_LOAD_BANK: begin
                    next_bank = {`LMM_BANK_TOP_ZERO, operand[`LMM_BANK_LIT_HI:0]};
                end
                default: begin
                    next_done = 1'b0;
                end
            endcase
        end
    end

    // Architectural registers and pulses, all straight from flip-flops
    always_ff @(posedge clk) begin
        if (rst) begin
            accumulator          <= `LMM_ACC_RESET;
            bank_select_register <= `LMM_BANK_RESET;
            product_high_byte    <= `LMM_PROD_RESET;
            product_low_byte     <= `LMM_PROD_RESET;
            file_wr              <= '0;
            instr_done           <= 1'b0;
        end else begin
            accumulator          <= next_accumulator;
            bank_select_register <= next_bank;
            product_high_byte    <= next_prod_hi;
            product_low_byte     <= next_prod_lo;
            file_wr              <= next_file_wr;
            instr_done           <= next_done;
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    a_phase_ring_order: assert property (@(posedge clk) disable iff (rst)
        phase == LMM_Q1 |=> phase == LMM_Q2 ##1 phase == LMM_Q3 ##1 phase == LMM_Q4
        ##1 phase == LMM_Q1)
        else $error("quarter phases out of order");

    a_load_lit_acc: assert property (@(posedge clk) disable iff (rst)
        (phase == LMM_Q1 && instr_valid && instr_word[15:8] == 8'h0E)
        |-> ##4 accumulator == $past(instr_word[7:0], 4) && instr_done)
        else $error("literal not loaded into accumulator");

    a_mult_decode: assert property (@(posedge clk) disable iff (rst)
        (phase == LMM_Q1 && instr_valid && instr_word[15:8] == 8'h0D)
        |=> dec.op == LMM_OP_MULTIPLY)
        else $error("multiply opcode not decoded");

    a_mult_product: assert property (@(posedge clk) disable iff (rst)
        (phase == LMM_Q1 && instr_valid && instr_word[15:8] == 8'h0D)
        |-> ##4 {product_high_byte, product_low_byte}
            == $past(accumulator, 4) * $past(instr_word[7:0], 4)
            && accumulator == $past(accumulator, 4))
        else $error("product wrong or accumulator modified");

    a_mult_no_side: assert property (@(posedge clk) disable iff (rst)
        (phase == LMM_Q1 && instr_valid && instr_word[15:8] == 8'h0D)
        |-> ##4 !file_wr.en && $stable(bank_select_register))
        else $error("multiply disturbed other state");

    a_mult_zero_stored: assert property (@(posedge clk) disable iff (rst)
        (phase == LMM_Q1 && instr_valid && instr_word[15:8] == 8'h0D
         && instr_word[7:0] == 8'h00)
        |-> ##4 product_high_byte == 8'h00 && product_low_byte == 8'h00)
        else $error("zero product not stored");

    a_store_write: assert property (@(posedge clk) disable iff (rst)
        (phase == LMM_Q1 && instr_valid && instr_word[15:9] == 7'h37 && instr_word[8])
        |-> ##4 file_wr.en && file_wr.data == $past(accumulator, 4)
            && file_wr.addr == {$past(bank_select_register[5:0], 4), $past(instr_word[7:0], 4)})
        else $error("banked store wrong");

    a_store_indexed: assert property (@(posedge clk) disable iff (rst)
        (phase == LMM_Q1 && instr_valid && instr_word[15:9] == 7'h37 && !instr_word[8]
         && ext_set_enable && instr_word[7:0] <= 8'h5F)
        |-> ##4 file_wr.en
            && file_wr.addr == 14'($past(index_base, 4) + {6'h00, $past(instr_word[7:0], 4)}))
        else $error("indexed store address wrong");

    a_bank_top_zero: assert property (@(posedge clk) disable iff (rst)
        (phase == LMM_Q1 && instr_valid && instr_word[15:6] == 10'h004)
        |-> ##4 bank_select_register == {2'h0, $past(instr_word[5:0], 4)})
        else $error("bank select load wrong");

endmodule : lmm_core

// ==== include/lmm_consts.svh ====
`ifndef LMM_CONSTS_SVH
`define LMM_CONSTS_SVH

// Opcode fields, matched against the top bits of the instruction word
`define LMM_OPC_LOAD_BANK      10'h004
`define LMM_OPC_LOAD_LIT       8'h0E
`define LMM_OPC_MULTIPLY       8'h0D
`define LMM_OPC_STORE_ACC      7'h37

// Field positions inside the instruction word
`define LMM_OPC8_HI            15
`define LMM_OPC8_LO            8
`define LMM_OPC10_LO           6
`define LMM_OPC7_LO            9
`define LMM_ACCESS_BIT         8
`define LMM_BANK_LIT_HI        5
`define LMM_LIT_HI             7

// Addressing
`define LMM_INDEX_LIMIT        8'h5F
`define LMM_ACCESS_LOW_BANK    6'h00
`define LMM_ACCESS_HIGH_BANK   6'h3F
`define LMM_BANK_TOP_ZERO      2'h0

// Reset values
`define LMM_ACC_RESET          8'h00
`define LMM_BANK_RESET         8'h00
`define LMM_PROD_RESET         8'h00
`define LMM_ADDR_RESET         14'h0000

`endif

// ==== include/lmm_pkg.sv ====
package lmm_pkg;

    // Quarter phases of one instruction cycle, one-hot
    typedef enum logic [3:0] {
        LMM_Q1 = 4'h1,
        LMM_Q2 = 4'h2,
        LMM_Q3 = 4'h4,
        LMM_Q4 = 4'h8
    } lmm_phase_t;

    // Decoded operation kinds
    typedef enum logic [2:0] {
        LMM_OP_NONE       = 3'h0,
        LMM_OP_LOAD_LIT   = 3'h1,
        LMM_OP_STORE_ACC  = 3'h2,
        LMM_OP_LOAD_BANK  = 3'h3,
        LMM_OP_MULTIPLY   = 3'h4
    } lmm_op_t;

    // Decoded instruction held through the cycle
    typedef struct packed {
        lmm_op_t     op;
        logic [7:0]  lit;
        logic        banked;
        logic        ext_en;
        logic [13:0] index_base;
    } lmm_dec_t;

    // File register write request
    typedef struct packed {
        logic        en;
        logic [13:0] addr;
        logic [7:0]  data;
    } lmm_file_wr_t;

endpackage : lmm_pkg

// ==== tb/lmm_core_test.sv ====
`timescale 1ns/1ps

module lmm_core_test;
    import lmm_pkg::*;

    logic          clk;
    logic          rst;
    logic          instr_valid;
    logic [15:0]   instr_word;
    logic          ext_set_enable;
    logic [13:0]   index_base;
    lmm_phase_t    phase;
    logic [7:0]    accumulator;
    logic [7:0]    bank_select_register;
    logic [7:0]    product_high_byte;
    logic [7:0]    product_low_byte;
    lmm_file_wr_t  file_wr;
    logic          instr_done;
    int            err_count;
    int            n_compared;

    lmm_core lmm_core_inst (
        .clk                  (clk),
        .rst                  (rst),
        .instr_valid          (instr_valid),
        .instr_word           (instr_word),
        .ext_set_enable       (ext_set_enable),
        .index_base           (index_base),
        .phase                (phase),
        .accumulator          (accumulator),
        .bank_select_register (bank_select_register),
        .product_high_byte    (product_high_byte),
        .product_low_byte     (product_low_byte),
        .file_wr              (file_wr),
        .instr_done           (instr_done)
    );

    // Free-running 50 ns clock
    always #25 clk = ~clk;

    // ****************************************
    // Shared helpers
    // ****************************************
    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    // Issue one word at Q1; junk stays on the inputs through Q2/Q3 so late sampling shows
    task automatic exec(input logic [15:0] w, input logic ext, input logic [13:0] base,
                        input logic exp_done, input logic exp_wr);
        chk("phase", {12'h000, LMM_Q1}, {12'h000, phase});
        instr_word = w;
        ext_set_enable = ext;
        index_base = base;
        instr_valid = 1'b1;
        @(negedge clk);
        instr_word = 16'h0E99;
        ext_set_enable = ~ext;
        index_base = ~base;
        repeat (2) @(negedge clk);
        instr_valid = 1'b0;
        @(negedge clk);
        chk("instr_done", {15'h0000, exp_done}, {15'h0000, instr_done});
        chk("file_wr_en", {15'h0000, exp_wr}, {15'h0000, file_wr.en});
    endtask : exec

    task automatic st(input logic [15:0] w, input logic ext, input logic [13:0] base,
                      input logic [13:0] addr);
        exec(w, ext, base, 1'b1, 1'b1);
        chk("file_wr_addr", {2'h0, addr}, {2'h0, file_wr.addr});
        chk("file_wr_data", 16'h004F, {8'h00, file_wr.data});
    endtask : st

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic sc_reset_values;
        chk("acc_rst", 16'h0000, {8'h00, accumulator});
        chk("bank_rst", 16'h0000, {8'h00, bank_select_register});
        chk("prod_rst", 16'h0000, {product_high_byte, product_low_byte});
        chk("done_rst", 16'h0000, {15'h0000, instr_done});
        chk("phase_rst", {12'h000, LMM_Q1}, {12'h000, phase});
        chk("wr_rst", 16'h0000, {15'h0000, file_wr.en});
    endtask : sc_reset_values

    task automatic sc_load_literal;
        exec(16'h0E5A, 1'b0, 14'h0000, 1'b1, 1'b0);
        chk("acc", 16'h005A, {8'h00, accumulator});
        exec(16'h0EFF, 1'b0, 14'h0000, 1'b1, 1'b0);
        chk("acc", 16'h00FF, {8'h00, accumulator});
    endtask : sc_load_literal

    task automatic sc_multiply;
        exec(16'h0EE2, 1'b0, 14'h0000, 1'b1, 1'b0);
        exec(16'h0DC4, 1'b0, 14'h0000, 1'b1, 1'b0);
        chk("prod", 16'hAD08, {product_high_byte, product_low_byte});
        chk("acc_kept", 16'h00E2, {8'h00, accumulator});
        exec(16'h0D00, 1'b0, 14'h0000, 1'b1, 1'b0);
        chk("prod_zero", 16'h0000, {product_high_byte, product_low_byte});
        exec(16'h0EFF, 1'b0, 14'h0000, 1'b1, 1'b0);
        exec(16'h0DFF, 1'b0, 14'h0000, 1'b1, 1'b0);
        chk("prod_max", 16'hFE01, {product_high_byte, product_low_byte});
    endtask : sc_multiply

    // Upper literal bits set means the word matches no opcode, so no bank change
    task automatic sc_bank;
        exec(16'h013F, 1'b0, 14'h0000, 1'b1, 1'b0);
        chk("bank", 16'h003F, {8'h00, bank_select_register});
        exec(16'h01FF, 1'b0, 14'h0000, 1'b0, 1'b0);
        chk("bank_kept", 16'h003F, {8'h00, bank_select_register});
        exec(16'h0105, 1'b0, 14'h0000, 1'b1, 1'b0);
        chk("bank", 16'h0005, {8'h00, bank_select_register});
    endtask : sc_bank

    // Store right after the load checks the new accumulator is seen
    task automatic sc_store;
        exec(16'h0E4F, 1'b0, 14'h0000, 1'b1, 1'b0);
        st(16'h6F10, 1'b0, 14'h0000, 14'h0510);
        st(16'h6E10, 1'b0, 14'h0000, 14'h0010);
        st(16'h6E60, 1'b0, 14'h0000, 14'h3F60);
        st(16'h6E5F, 1'b1, 14'h0100, 14'h015F);
        st(16'h6E60, 1'b1, 14'h0100, 14'h3F60);
        st(16'h6F20, 1'b1, 14'h0100, 14'h0520);
    endtask : sc_store

    task automatic sc_refuse;
        exec(16'h0000, 1'b0, 14'h0000, 1'b0, 1'b0);
        instr_word = 16'h0E11;
        repeat (4) @(negedge clk);
        chk("acc_idle", 16'h004F, {8'h00, accumulator});
        chk("done_idle", 16'h0000, {15'h0000, instr_done});
    endtask : sc_refuse

    task automatic sc_mid_reset;
        exec(16'h0E33, 1'b0, 14'h0000, 1'b1, 1'b0);
        @(negedge clk);
        rst = 1'b1;
        repeat (2) @(negedge clk);
        rst = 1'b0;
        sc_reset_values();
        exec(16'h0E77, 1'b0, 14'h0000, 1'b1, 1'b0);
        chk("acc", 16'h0077, {8'h00, accumulator});
    endtask : sc_mid_reset

    // ****************************************
    // Verdict and sequencing
    // ****************************************
    task automatic complete_run;
        if (err_count == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : complete_run

    // Whole sequence needs about 90 cycles; far more is a hang
    initial begin
        repeat (2000) @(posedge clk);
        err_count++;
        complete_run();
    end

    initial begin
        clk = 1'b0;
        rst = 1'b1;
        instr_valid = 1'b0;
        instr_word = 16'h0000;
        ext_set_enable = 1'b0;
        index_base = 14'h0000;
        err_count = 0;
        n_compared = 0;
        repeat (4) @(negedge clk);
        rst = 1'b0;
        sc_reset_values();
        sc_load_literal();
        sc_multiply();
        sc_bank();
        sc_store();
        sc_refuse();
        sc_mid_reset();
        complete_run();
    end

endmodule : lmm_core_test
